//--- ict_consts.svh
`ifndef ICT_CONSTS_SVH
`define ICT_CONSTS_SVH
`define ICT_WORD_PENALTY 8'h04
`define ICT_JCC_TAKEN 8'h10
`define ICT_JCC_NOT_TAKEN 8'h04
`define ICT_JCC_BYTES 3'h2
`define ICT_JCXZ_TAKEN 8'h12
`define ICT_JCXZ_NOT_TAKEN 8'h06
`define ICT_FLAG_LOAD_CLK 8'h04
`define ICT_LPTR_CLK 8'h10
`define ICT_LPTR_XFER 3'h2
`define ICT_LEA_CLK 8'h02
`define ICT_FLAG_POP_CLK 8'h08
`define ICT_FLAG_POP_XFER 3'h1
`define ICT_NOT_REG_CLK 8'h03
`define ICT_NOT_MEM_CLK 8'h10
`define ICT_NOT_MEM_XFER 3'h2
`define ICT_NEGATE_REG_CLK 8'h03
`define ICT_NEGATE_MEM_CLK 8'h10
`define ICT_NEGATE_MEM_XFER 3'h2
`define ICT_NMI_CLK 8'h32
`define ICT_NMI_XFER 3'h5
`define ICT_NOP_CLK 8'h03
`define ICT_ONE_BYTE 3'h1
`define ICT_TWO_BYTES 3'h2
`endif

//--- ict_pkg.sv
package ict_pkg;
  typedef enum logic [3:0] {
    ICT_OP_JCC = 4'h0,
    ICT_OP_JCXZ = 4'h1,
    ICT_OP_FLAG_LOAD = 4'h2,
    ICT_OP_LPTR = 4'h3,
    ICT_OP_LEA = 4'h4,
    ICT_OP_FLAG_POP = 4'h5,
    ICT_OP_NOT = 4'h6,
    ICT_OP_NEGATE = 4'h7,
    ICT_OP_NMI = 4'h8,
    ICT_OP_NOP = 4'h9
  } ict_op_e;
  typedef enum logic [2:0] {
    ICT_IDLE = 3'b001,
    ICT_CALC = 3'b010,
    ICT_DONE = 3'b100
  } ict_state_e;
endpackage

//--- ict_calc_if.sv
`timescale 1ns/1ps
interface ict_calc_if;
  logic [3:0] op;
  logic mem_form;
  logic taken;
  logic odd_addr;
  logic narrow_bus;
  logic [7:0] addr_time;
  logic [15:0] dest;
  logic [15:0] clocks;
  logic [2:0] xfers;
  logic [2:0] bytes;
  logic carry;
  logic carry_valid;
  modport host (output op, mem_form, taken, odd_addr, narrow_bus, addr_time,
    dest, input clocks, xfers, bytes, carry, carry_valid);
  modport calc (input op, mem_form, taken, odd_addr, narrow_bus, addr_time,
    dest, output clocks, xfers, bytes, carry, carry_valid);
endinterface

//--- ict_calc.sv
`timescale 1ns/1ps
`include "ict_consts.svh"
module ict_calc (
  // Request and result
  ict_calc_if.calc c
);
  logic [7:0] base;
  logic [2:0] nx;
  logic [2:0] nb;
  logic use_addr_time;
  logic [15:0] pen;
  always_comb begin
    base = `ICT_NOP_CLK;
    nx = 3'h0;
    nb = `ICT_ONE_BYTE;
    use_addr_time = 1'b0;
    c.carry = 1'b0;
    c.carry_valid = 1'b0;
    case (c.op)
      4'h0: begin
        base = c.taken ? `ICT_JCC_TAKEN : `ICT_JCC_NOT_TAKEN;
        nb = `ICT_JCC_BYTES;
      end
      4'h1: begin
        base = c.taken ? `ICT_JCXZ_TAKEN : `ICT_JCXZ_NOT_TAKEN;
        nb = `ICT_TWO_BYTES;
      end
      4'h2: base = `ICT_FLAG_LOAD_CLK;
      4'h3: begin
        base = `ICT_LPTR_CLK;
        nx = `ICT_LPTR_XFER;
        nb = `ICT_TWO_BYTES;
        use_addr_time = 1'b1;
      end
      4'h4: begin
        base = `ICT_LEA_CLK;
        nb = `ICT_TWO_BYTES;
        use_addr_time = 1'b1;
      end
      4'h5: begin
        base = `ICT_FLAG_POP_CLK;
        nx = `ICT_FLAG_POP_XFER;
      end
      4'h6: begin
        nb = `ICT_TWO_BYTES;
        base = c.mem_form ? `ICT_NOT_MEM_CLK : `ICT_NOT_REG_CLK;
        nx = c.mem_form ? `ICT_NOT_MEM_XFER : 3'h0;
        use_addr_time = c.mem_form;
      end
      4'h7: begin
        nb = `ICT_TWO_BYTES;
        base = c.mem_form ? `ICT_NEGATE_MEM_CLK : `ICT_NEGATE_REG_CLK;
        nx = c.mem_form ? `ICT_NEGATE_MEM_XFER : 3'h0;
        use_addr_time = c.mem_form;
        c.carry = (c.dest != 16'h0000);
        c.carry_valid = 1'b1;
      end
      4'h8: begin
        base = `ICT_NMI_CLK;
        nx = `ICT_NMI_XFER;
        nb = 3'h0;
      end
      default: base = `ICT_NOP_CLK;
    endcase
    pen = 16'h0000;
    if (c.narrow_bus || c.odd_addr) begin
      pen = 16'({13'h0, nx} * {8'h0, `ICT_WORD_PENALTY});
    end
    c.clocks = 16'({8'h0, base} + (use_addr_time ? {8'h0, c.addr_time} : 16'h0)
      + pen);
    c.xfers = nx;
    c.bytes = nb;
  end
endmodule

//--- ict_timing.sv
`timescale 1ns/1ps
`include "ict_consts.svh"
module ict_timing (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Request
  input wire logic req_i,
  input wire logic [3:0] op_i,
  input wire logic mem_form_i,
  input wire logic taken_i,
  input wire logic odd_addr_i,
  input wire logic narrow_bus_i,
  input wire logic [7:0] effective_address_time_i,
  input wire logic [15:0] dest_i,
  // Result
  output logic done_o,
  output logic [15:0] clocks_o,
  output logic [2:0] xfers_o,
  output logic [2:0] bytes_o,
  output logic carry_o,
  output logic carry_valid_o
);
  ict_calc_if cif ();
  ict_pkg::ict_state_e state_q;
  logic [3:0] op_q;
  logic mem_q, taken_q, odd_q, narrow_q;
  logic [7:0] addr_time_q;
  logic [15:0] dest_q;

  // ------------------------------------------------------------
  // Request capture
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_q <= 4'h0;
      mem_q <= 1'b0;
      taken_q <= 1'b0;
      odd_q <= 1'b0;
      narrow_q <= 1'b0;
      addr_time_q <= 8'h00;
      dest_q <= 16'h0000;
    end else if (req_i && state_q == ict_pkg::ICT_IDLE) begin
      op_q <= op_i;
      mem_q <= mem_form_i;
      taken_q <= taken_i;
      odd_q <= odd_addr_i;
      narrow_q <= narrow_bus_i;
      addr_time_q <= effective_address_time_i;
      dest_q <= dest_i;
    end
  end

  assign cif.op = op_q;
  assign cif.mem_form = mem_q;
  assign cif.taken = taken_q;
  assign cif.odd_addr = odd_q;
  assign cif.narrow_bus = narrow_q;
  assign cif.addr_time = addr_time_q;
  assign cif.dest = dest_q;

  ict_calc u_calc (
    .c(cif.calc)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ict_pkg::ICT_IDLE;
    end else begin
      case (state_q)
        ict_pkg::ICT_IDLE: begin
          if (req_i) begin
            state_q <= ict_pkg::ICT_CALC;
          end
        end
        ict_pkg::ICT_CALC: state_q <= ict_pkg::ICT_DONE;
        ict_pkg::ICT_DONE: state_q <= ict_pkg::ICT_IDLE;
        default: state_q <= ict_pkg::ICT_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Result registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_o <= 1'b0;
      clocks_o <= 16'h0000;
      xfers_o <= 3'h0;
      bytes_o <= 3'h0;
      carry_o <= 1'b0;
      carry_valid_o <= 1'b0;
    end else begin
      done_o <= (state_q == ict_pkg::ICT_CALC);
      if (state_q == ict_pkg::ICT_CALC) begin
        clocks_o <= cif.clocks;
        xfers_o <= cif.xfers;
        bytes_o <= cif.bytes;
        carry_o <= cif.carry;
        carry_valid_o <= cif.carry_valid;
      end
    end
  end

  // ------------------------------------------------------------
  // Handshake checks
  // ------------------------------------------------------------
  // Request accepted on this edge
  sequence s_issue;
    state_q == ict_pkg::ICT_IDLE && req_i;
  endsequence

  // Block is working on an accepted request
  sequence s_busy;
    state_q != ict_pkg::ICT_IDLE;
  endsequence

  // Neither word penalty applies
  sequence s_no_penalty;
    !narrow_bus_i && !odd_addr_i;
  endsequence

  a_done_latency: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue |-> ##2 done_o)
    else $error("done not two cycles after request");
  a_done_pulse: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    done_o |=> !done_o)
    else $error("done held longer than one cycle");
  a_busy_refuse: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_busy |=> ($stable(op_q) && $stable(dest_q) && $stable(addr_time_q)))
    else $error("request taken while busy");
  a_results_stand: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !done_o |-> ($stable(clocks_o) && $stable(xfers_o) && $stable(bytes_o)
    && $stable(carry_o) && $stable(carry_valid_o)))
    else $error("result changed without done");

  // ------------------------------------------------------------
  // Timing checks
  // ------------------------------------------------------------
  a_jcc_taken: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 s_no_penalty ##0 (op_i == 4'h0 && taken_i)
    |-> ##2 (clocks_o == 16'h0010 && bytes_o == 3'h2))
    else $error("taken short jump wrong");
  a_jcc_fall: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h0 && !taken_i)
    |-> ##2 (clocks_o == 16'h0004 && xfers_o == 3'h0))
    else $error("untaken short jump wrong");
  a_jcc_no_penalty: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h0 && (narrow_bus_i || odd_addr_i))
    |-> ##2 (xfers_o == 3'h0 && bytes_o == 3'h2 && clocks_o ==
    ($past(taken_i, 2) ? 16'h0010 : 16'h0004)))
    else $error("short jump charged a bus penalty");
  a_flag_load_time: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h2)
    |-> ##2 (clocks_o == 16'h0004 && xfers_o == 3'h0 && bytes_o == 3'h1))
    else $error("flag load time wrong");
  a_lptr_time: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 s_no_penalty ##0 (op_i == 4'h3)
    |-> ##2 (xfers_o == 3'h2 && clocks_o == 16'h0010
    + {8'h00, $past(effective_address_time_i, 2)}))
    else $error("pointer load time wrong");
  a_lptr_narrow: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h3 && narrow_bus_i)
    |-> ##2 (xfers_o == 3'h2 && clocks_o == 16'h0018
    + {8'h00, $past(effective_address_time_i, 2)}))
    else $error("pointer load on narrow bus wrong");
  a_flag_pop_time: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h5 && narrow_bus_i)
    |-> ##2 (clocks_o == 16'h000C && xfers_o == 3'h1))
    else $error("pop flags time wrong");
  a_flag_pop_wide: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h5 && !narrow_bus_i)
    |-> ##2 (xfers_o == 3'h1 && bytes_o == 3'h1 && clocks_o ==
    ($past(odd_addr_i, 2) ? 16'h000C : 16'h0008)))
    else $error("pop flags on wide bus wrong");
  a_not_reg: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h6 && !mem_form_i)
    |-> ##2 (clocks_o == 16'h0003 && bytes_o == 3'h2))
    else $error("complement register time wrong");
  a_not_mem_ea: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 s_no_penalty ##0 (op_i == 4'h6 && mem_form_i)
    |-> ##2 (xfers_o == 3'h2 && clocks_o == 16'h0010
    + {8'h00, $past(effective_address_time_i, 2)}))
    else $error("complement memory time wrong");
  a_not_mem_odd: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h6 && mem_form_i && odd_addr_i && !narrow_bus_i)
    |-> ##2 (xfers_o == 3'h2 && clocks_o == 16'h0018
    + {8'h00, $past(effective_address_time_i, 2)}))
    else $error("complement at odd address wrong");
  a_negate_carry: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h7)
    |-> ##2 (carry_valid_o && carry_o == ($past(dest_i, 2) != 16'h0000)))
    else $error("negate carry wrong");
  a_negate_zero: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h7 && dest_i == 16'h0000)
    |-> ##2 (carry_valid_o && !carry_o))
    else $error("negate of zero left carry set");
  a_carry_only_negate: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i != 4'h7) |-> ##2 !carry_valid_o)
    else $error("carry reported for a non negate");
  a_nmi_odd: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 (op_i == 4'h8 && odd_addr_i)
    |-> ##2 (clocks_o == 16'h0046 && xfers_o == 3'h5))
    else $error("interrupt entry time wrong");
  a_nmi_wide: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_issue ##0 s_no_penalty ##0 (op_i == 4'h8)
    |-> ##2 (clocks_o == 16'h0032 && xfers_o == 3'h5))
    else $error("interrupt entry without penalty wrong");
endmodule

//--- ict_bus_side.sv
`timescale 1ns/1ps
// ----------------------------------------
// Memory side: data bus width and alignment
// ----------------------------------------
module ict_bus_side (
  // Mode select from the bench
  input wire logic [1:0] mode_i,
  // Bus properties seen by the block
  output logic narrow_bus_o,
  output logic odd_addr_o
);
  assign narrow_bus_o = mode_i[1];
  assign odd_addr_o = mode_i[0];
endmodule

//--- tb_insn_cycle_timing_subset.sv
`timescale 1ns/1ps
module tb_insn_cycle_timing_subset;
  typedef struct packed {
    logic [15:0] c;
    logic [2:0] x;
    logic [2:0] b;
    logic bk;
    logic cv;
    logic cy;
  } ict_exp_s;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_i = 1'b0;
  logic [3:0] op_i = 4'h0;
  logic mem_form_i = 1'b0;
  logic taken_i = 1'b0;
  logic [1:0] bus_mode = 2'h0;
  logic [7:0] adt_i = 8'h00;
  logic [15:0] dest_i = 16'h0000;
  logic odd_addr_i, narrow_bus_i, done_o, carry_o, carry_valid_o;
  logic [15:0] clocks_o;
  logic [2:0] xfers_o, bytes_o;
  int n_errors = 0;
  int checked = 0;
  int seed;
  ict_exp_s exp_q[$];
  ict_exp_s e;
  always #10 sys_clk_i = ~sys_clk_i;
  ict_bus_side BUS (.mode_i(bus_mode), .narrow_bus_o(narrow_bus_i),
    .odd_addr_o(odd_addr_i));
  ict_timing DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .req_i(req_i), .op_i(op_i), .mem_form_i(mem_form_i),
    .taken_i(taken_i), .odd_addr_i(odd_addr_i),
    .narrow_bus_i(narrow_bus_i), .effective_address_time_i(adt_i),
    .dest_i(dest_i), .done_o(done_o), .clocks_o(clocks_o),
    .xfers_o(xfers_o), .bytes_o(bytes_o), .carry_o(carry_o),
    .carry_valid_o(carry_valid_o));
  task automatic chk(string n, logic [15:0] ex, logic [15:0] got);
    checked++;
    if (got !== ex) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic ict_exp_s model(logic [3:0] op, logic m, logic t,
    logic [1:0] md, logic [7:0] adt, logic [15:0] d);
    ict_exp_s r;
    r = '{c:16'h0003, x:3'h0, b:3'h1, bk:1'b1, cv:1'b0, cy:(d != 16'h0000)};
    case (op)
      4'h0: begin r.c = t ? 16'h0010 : 16'h0004; r.b = 3'h2; end
      4'h1: begin r.c = t ? 16'h0012 : 16'h0006; r.b = 3'h2; end
      4'h2: r.c = 16'h0004;
      4'h3: begin r.c = 16'h0010 + adt; r.x = 3'h2; r.bk = 1'b0; end
      4'h4: begin r.c = 16'h0002 + adt; r.bk = 1'b0; end
      4'h5: begin r.c = 16'h0008; r.x = 3'h1; end
      4'h6, 4'h7: begin
        r.c = m ? 16'h0010 + adt : 16'h0003;
        r.x = m ? 3'h2 : 3'h0;
        r.b = 3'h2;
        r.bk = !m;
        r.cv = (op == 4'h7);
      end
      4'h8: begin r.c = 16'h0032; r.x = 3'h5; r.b = 3'h0; end
      default: ;
    endcase
    if (md != 2'h0) r.c = r.c + {11'h000, r.x, 2'h0};
    return r;
  endfunction
  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    #1;
    if (done_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected result", 16'h0000, 16'h0001);
      end else begin
        e = exp_q.pop_front();
        chk("clocks", e.c, clocks_o);
        chk("xfers", {13'h0, e.x}, {13'h0, xfers_o});
        if (e.bk) chk("bytes", {13'h0, e.b}, {13'h0, bytes_o});
        chk("carry valid", {15'h0, e.cv}, {15'h0, carry_valid_o});
        if (e.cv) chk("carry", {15'h0, e.cy}, {15'h0, carry_o});
      end
    end
  end
  task automatic req(logic [3:0] op, logic m, logic t, logic [1:0] md,
    logic zd, bit hold);
    int i;
    @(negedge sys_clk_i);
    req_i = 1'b1;
    op_i = op;
    mem_form_i = m;
    taken_i = t;
    bus_mode = md;
    adt_i = 8'($urandom);
    dest_i = zd ? 16'h0000 : 16'($urandom);
    exp_q.push_back(model(op, m, t, md, adt_i, dest_i));
    @(negedge sys_clk_i);
    req_i = hold;
    op_i = op + 4'h1;
    for (i = 0; i < 8 && done_o !== 1'b1; i++) @(negedge sys_clk_i);
    req_i = 1'b0;
    if (i == 8) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic rst_chk;
    chk("reset clocks", 16'h0000, clocks_o);
    chk("reset flags", 16'h0000, {10'h0, done_o, xfers_o, bytes_o,
      carry_o, carry_valid_o});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = $urandom(33690);
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    rst_chk();
    for (int op = 0; op < 12; op++) begin
      for (int k = 0; k < 8; k++) begin
        req(4'(op), k[0], k[1], k[2:1], k[0], k[2]);
      end
    end
    for (int n = 0; n < 150; n++) begin
      req(4'($urandom), 1'($urandom), 1'($urandom), 2'($urandom),
        ($urandom_range(0, 3) == 0), 1'($urandom));
    end
    @(negedge sys_clk_i);
    sys_rst_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    rst_chk();
    req(4'h7, 1'b1, 1'b0, 2'h2, 1'b0, 1'b1);
    req(4'h5, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0);
    repeat (4) @(negedge sys_clk_i);
    chk("pending results", 16'h0000, 16'(exp_q.size()));
    end_sim();
  end
endmodule
